// ---- hw/codec_enable_sequencer.sv ----
// Codec master enable and soft start/shutdown sequencer, AHB-Lite slave.
// Assumes a single master, word transfers, and an asynchronous sleep pin.
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps

module codec_enable_sequencer #(
  parameter int unsigned START_RAMP_CYC   = codec_seq_pkg::START_RAMP_CYC,
  parameter int unsigned START_SETTLE_CYC = codec_seq_pkg::START_SETTLE_CYC,
  parameter int unsigned STOP_RAMP_CYC    = codec_seq_pkg::STOP_RAMP_CYC,
  parameter int unsigned STOP_SETTLE_CYC  = codec_seq_pkg::STOP_SETTLE_CYC
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output wire logic        hreadyout,
  output wire logic        hresp,
  output wire logic [31:0] hrdata,
  input  wire logic        deep_sleep,
  output wire logic        codec_master_enable,
  output wire logic        codec_regs_reset_n,
  output wire logic [14:0] codec_settings,
  output wire logic        pop_ramp_active,
  output wire logic        seq_busy
);

  localparam int unsigned TW = codec_seq_pkg::TIMER_W;
  localparam int unsigned IW = codec_seq_pkg::IDX_W;
  localparam int unsigned SW = codec_seq_pkg::SETTINGS_W;

  typedef struct packed
  {
    logic                     dp_valid;
    logic                     dp_write;
    logic [IW-1:0]            dp_idx;
    logic                     rd_ready;
    logic [31:0]              rdata;
    logic                     enable;
    logic [SW-1:0]            settings;
    logic                     start_trig;
    logic                     stop_trig;
    codec_seq_pkg::seq_state_e fsm;
  } seq_s;

  seq_s r;
  seq_s next_r;

  logic          sleep;
  logic          tmr_load;
  logic [TW-1:0] tmr_count;
  logic          tmr_done;
  logic          dp_wr;
  logic          dp_rd_first;

  // ==========================================================================
  // Register index decode from a byte address
  function automatic logic [IW-1:0] reg_index(input logic [31:0] addr);
    reg_index = addr[codec_seq_pkg::IDX_LSB +: IW];
  endfunction : reg_index

  // Read value of one register
  function automatic logic [31:0] read_word(input logic [IW-1:0] idx,
                                            input seq_s          s);
    read_word = 32'h0000_0000;
    if (idx == codec_seq_pkg::POWER_CTRL_IDX)
      read_word = {16'h0000, s.enable, s.settings};
    else if (idx == codec_seq_pkg::SOFT_SEQ_IDX)
      read_word = {16'h0000, s.start_trig, s.stop_trig, 14'h0000};
  endfunction : read_word

  // ==========================================================================
  // Sleep pin crossing
  bit_sync u_sleep_sync
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .async_in (deep_sleep),
    .sync_out (sleep)
  );

  // Step timer shared by every sequence step
  step_timer #(
    .W (TW)
  ) u_step_timer
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .load    (tmr_load),
    .count   (tmr_count),
    .done    (tmr_done),
    .running ()
  );

  // ==========================================================================
  // Bus handshake: reads take one wait state so hrdata is registered
  assign dp_wr       = r.dp_valid && r.dp_write;
  assign dp_rd_first = r.dp_valid && !r.dp_write && !r.rd_ready;
  assign hreadyout   = ce && !dp_rd_first;
  assign hresp       = codec_seq_pkg::HRESP_OKAY;
  assign hrdata      = r.rdata;

  // Codec-facing outputs
  assign codec_master_enable = r.enable;
  assign codec_regs_reset_n  = r.enable;
  assign codec_settings      = r.settings;
  assign pop_ramp_active     = (r.fsm == codec_seq_pkg::SEQ_START_RAMP) ||
                               (r.fsm == codec_seq_pkg::SEQ_STOP_RAMP);
  assign seq_busy            = (r.fsm != codec_seq_pkg::SEQ_IDLE);

  // ==========================================================================
  // Next state: bus, register writes, then sequencer
  always_comb
  begin
    next_r    = r;
    tmr_load  = 1'b0;
    tmr_count = TW'(1);
    if (ce)
    begin
      // Data phase bookkeeping
      if (dp_rd_first)
      begin
        next_r.rdata    = read_word(r.dp_idx, r);
        next_r.rd_ready = 1'b1;
      end
      else
      begin
        next_r.dp_valid = 1'b0;
        next_r.rd_ready = 1'b0;
      end
      // Address phase capture
      if (hsel && hready && htrans[1] && !dp_rd_first)
      begin
        next_r.dp_valid = 1'b1;
        next_r.dp_write = hwrite;
        next_r.dp_idx   = reg_index(haddr);
      end

      if (dp_wr && (r.dp_idx == codec_seq_pkg::POWER_CTRL_IDX))
      begin
        next_r.enable   = hwdata[codec_seq_pkg::ENABLE_BIT];
        next_r.settings = hwdata[SW-1:0];
      end

      // start and stop trigger write
      // A pending trigger counts as busy, so a write cannot undo it
      if (dp_wr && (r.dp_idx == codec_seq_pkg::SOFT_SEQ_IDX) &&
          (r.fsm == codec_seq_pkg::SEQ_IDLE) &&
          !r.start_trig && !r.stop_trig)
      begin
        next_r.start_trig = hwdata[codec_seq_pkg::START_BIT];
        next_r.stop_trig  = hwdata[codec_seq_pkg::STOP_BIT];
      end

      // Sequencer steps; hardware wins over a same-cycle enable write
      case (r.fsm)
        codec_seq_pkg::SEQ_IDLE:
        begin
          if (r.stop_trig)
          begin
            next_r.fsm        = codec_seq_pkg::SEQ_STOP_RAMP;
            next_r.start_trig = 1'b0;
            tmr_load          = 1'b1;
            tmr_count         = TW'(STOP_RAMP_CYC);
          end
          else if (r.start_trig)
          begin
            next_r.fsm = codec_seq_pkg::SEQ_START_RAMP;
            tmr_load   = 1'b1;
            tmr_count  = TW'(START_RAMP_CYC);
          end
        end
        codec_seq_pkg::SEQ_START_RAMP:
        begin
          if (tmr_done)
          begin
            next_r.enable = 1'b1;
            next_r.fsm    = codec_seq_pkg::SEQ_START_SETTLE;
            tmr_load      = 1'b1;
            tmr_count     = TW'(START_SETTLE_CYC);
          end
        end
        codec_seq_pkg::SEQ_START_SETTLE:
        begin
          next_r.enable = 1'b1;
          if (tmr_done)
          begin
            next_r.start_trig = 1'b0;
            next_r.fsm        = codec_seq_pkg::SEQ_IDLE;
          end
        end
        codec_seq_pkg::SEQ_STOP_RAMP:
        begin
          if (tmr_done)
          begin
            next_r.enable = 1'b0;
            next_r.fsm    = codec_seq_pkg::SEQ_STOP_SETTLE;
            tmr_load      = 1'b1;
            tmr_count     = TW'(STOP_SETTLE_CYC);
          end
        end
        codec_seq_pkg::SEQ_STOP_SETTLE:
        begin
          next_r.enable = 1'b0;
          if (tmr_done)
          begin
            next_r.stop_trig = 1'b0;
            next_r.fsm       = codec_seq_pkg::SEQ_IDLE;
          end
        end
        default:
        begin
          next_r.fsm = codec_seq_pkg::SEQ_IDLE;
        end
      endcase

      if (sleep)
      begin
        next_r.enable     = 1'b0;
        next_r.start_trig = 1'b0;
        next_r.stop_trig  = 1'b0;
        next_r.fsm        = codec_seq_pkg::SEQ_IDLE;
        next_r.settings   = codec_seq_pkg::POWER_CTRL_RESET[SW-1:0];
      end

      if (!next_r.enable)
        next_r.settings = codec_seq_pkg::POWER_CTRL_RESET[SW-1:0];
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r            <= '0;
      r.fsm        <= codec_seq_pkg::SEQ_IDLE;
      r.enable     <=
        codec_seq_pkg::POWER_CTRL_RESET[codec_seq_pkg::ENABLE_BIT];
      r.start_trig <= codec_seq_pkg::SOFT_SEQ_RESET[codec_seq_pkg::START_BIT];
      r.stop_trig  <= codec_seq_pkg::SOFT_SEQ_RESET[codec_seq_pkg::STOP_BIT];
    end
    else
      r <= next_r;
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  held_default_a : assert property (
    !r.enable |-> (r.settings == '0))
    else $error("settings not at default while disabled");

  enable_clear_a : assert property (
    (ce && dp_wr && (r.dp_idx == codec_seq_pkg::POWER_CTRL_IDX) &&
     !hwdata[codec_seq_pkg::ENABLE_BIT] &&
     (r.fsm == codec_seq_pkg::SEQ_IDLE) && !r.start_trig && !sleep)
    |=> (!r.enable && (r.settings == '0)))
    else $error("enable write low did not reset");

  start_launch_a : assert property (
    (ce && (r.fsm == codec_seq_pkg::SEQ_IDLE) && r.start_trig &&
     !r.stop_trig && !sleep)
    |=> (r.fsm == codec_seq_pkg::SEQ_START_RAMP))
    else $error("soft start did not launch");

  start_enable_a : assert property (
    (r.fsm == codec_seq_pkg::SEQ_START_SETTLE) |-> r.enable)
    else $error("enable low during start settle");

  stop_launch_a : assert property (
    (ce && (r.fsm == codec_seq_pkg::SEQ_IDLE) && r.stop_trig && !sleep)
    |=> (r.fsm == codec_seq_pkg::SEQ_STOP_RAMP) ##1 pop_ramp_active)
    else $error("soft shutdown did not launch");

  stop_disable_a : assert property (
    (r.fsm == codec_seq_pkg::SEQ_STOP_SETTLE) |-> !r.enable)
    else $error("enable high during stop settle");

  sleep_off_a : assert property (
    (ce && sleep) |=> (!r.enable && !r.start_trig && !r.stop_trig &&
                       !seq_busy))
    else $error("deep sleep did not force codec off");

  sleep_lost_a : assert property (
    (ce && sleep) ##1 (ce && sleep) |-> (r.settings == '0))
    else $error("settings survived deep sleep");

  trig_done_a : assert property (
    (ce && (r.fsm == codec_seq_pkg::SEQ_START_SETTLE) && tmr_done)
    |=> (!r.start_trig && (r.fsm == codec_seq_pkg::SEQ_IDLE)))
    else $error("start trigger not cleared on completion");

  stop_done_a : assert property (
    (ce && (r.fsm == codec_seq_pkg::SEQ_STOP_SETTLE) && tmr_done)
    |=> (!r.stop_trig && (r.fsm == codec_seq_pkg::SEQ_IDLE)))
    else $error("stop trigger not cleared on completion");

  start_hold_a : assert property (
    ((r.fsm == codec_seq_pkg::SEQ_START_RAMP) ||
     (r.fsm == codec_seq_pkg::SEQ_START_SETTLE)) |-> r.start_trig)
    else $error("start trigger dropped before completion");

  reset_off_a : assert property (
    $rose(hresetn) |-> (!r.enable && !r.start_trig && !r.stop_trig &&
                        (r.fsm == codec_seq_pkg::SEQ_IDLE)))
    else $error("state not cleared by reset");

  busy_ignore_a : assert property (
    (ce && dp_wr && (r.dp_idx == codec_seq_pkg::SOFT_SEQ_IDX) &&
     (r.fsm == codec_seq_pkg::SEQ_START_RAMP))
    |=> !r.stop_trig)
    else $error("trigger write accepted while busy");

  en_write_a : assert property (
    (ce && dp_wr && (r.dp_idx == codec_seq_pkg::POWER_CTRL_IDX) &&
     hwdata[codec_seq_pkg::ENABLE_BIT] && !sleep &&
     (r.fsm == codec_seq_pkg::SEQ_IDLE))
    |=> (r.enable && (r.settings == SW'($past(hwdata)))))
    else $error("enabled settings not kept");

  read_wait_a : assert property (
    (ce && dp_rd_first) |-> !hreadyout ##1 (!ce || hreadyout))
    else $error("read data phase length wrong");

endmodule : codec_enable_sequencer

// ---- pkg/codec_seq_pkg.sv ----
// Constants, states and register layout for the codec enable sequencer.
// Assumes one 200 MHz bus clock and word-wide AHB-Lite register access.

package codec_seq_pkg;

  // ==========================================================================
  // Clock and sequence timing
  localparam int unsigned CLK_PERIOD_NS      = 5;
  localparam int unsigned START_RAMP_NS      = 2000;
  localparam int unsigned START_SETTLE_NS    = 1000;
  localparam int unsigned STOP_RAMP_NS       = 2000;
  localparam int unsigned STOP_SETTLE_NS     = 1000;
  localparam int unsigned START_RAMP_CYC     =
    (START_RAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned START_SETTLE_CYC   =
    (START_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STOP_RAMP_CYC      =
    (STOP_RAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STOP_SETTLE_CYC    =
    (STOP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W            = 16;

  // ==========================================================================
  // Register map: index, byte address is four times the index
  localparam int unsigned IDX_W              = 8;
  localparam logic [7:0]  POWER_CTRL_IDX     = 8'h02;
  localparam logic [7:0]  SOFT_SEQ_IDX       = 8'h4c;
  localparam int unsigned IDX_LSB            = 2;
  localparam int unsigned REG_W              = 16;
  localparam int unsigned ENABLE_BIT         = 15;
  localparam int unsigned START_BIT          = 15;
  localparam int unsigned STOP_BIT           = 14;
  localparam int unsigned SETTINGS_W         = 15;
  localparam logic [15:0] POWER_CTRL_RESET   = 16'h0000;
  localparam logic [15:0] SOFT_SEQ_RESET     = 16'h0000;

  // ==========================================================================
  // Bus encodings
  localparam logic [1:0]  HTRANS_NONSEQ      = 2'h2;
  localparam logic        HRESP_OKAY         = 1'h0;

  // Sequencer states
  typedef enum logic [2:0]
  {
    SEQ_IDLE,
    SEQ_START_RAMP,
    SEQ_START_SETTLE,
    SEQ_STOP_RAMP,
    SEQ_STOP_SETTLE
  } seq_state_e;

endpackage : codec_seq_pkg

// ---- hw/bit_sync.sv ----
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the level is stable for at least two clock cycles.
`timescale 1ns/1ps

module bit_sync
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic async_in,
  output wire logic sync_out
);

  typedef struct packed
  {
    logic meta;
    logic stable;
  } sync_s;

  sync_s r;
  sync_s next_r;

  // ==========================================================================
  // Next state: first stage feeds only the second
  always_comb
  begin
    next_r = r;
    if (ce)
    begin
      next_r.meta   = async_in;
      next_r.stable = r.meta;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      r <= '0;
    else
      r <= next_r;
  end

  assign sync_out = r.stable;

endmodule : bit_sync

// ---- hw/step_timer.sv ----
// Down-counter that times one step of a power sequence.
// Assumes load counts of at least one; done pulses on the last cycle.
`timescale 1ns/1ps

module step_timer #(
  parameter int unsigned W = 16
)
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output wire logic         done,
  output wire logic         running
);

  typedef struct packed
  {
    logic [W-1:0] cnt;
    logic         run;
  } timer_s;

  timer_s r;
  timer_s next_r;

  // Last counted cycle
  assign done    = ce && r.run && (r.cnt == W'(1));
  assign running = r.run;

  // ==========================================================================
  // Next state: load wins over counting
  always_comb
  begin
    next_r = r;
    if (ce)
    begin
      if (load)
      begin
        next_r.cnt = count;
        next_r.run = 1'b1;
      end
      else if (r.run)
      begin
        next_r.cnt = r.cnt - W'(1);
        if (r.cnt == W'(1))
          next_r.run = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      r <= '0;
    else
      r <= next_r;
  end

endmodule : step_timer

// ---- bench/tb_codec_enable_sequencer.sv ----
// Self-checking bench for the codec enable sequencer over AHB-Lite.
// Assumes the sequencer package and design modules are compiled first.
`timescale 1ns/1ps

// Compare one value and count it
`define CHECK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module tb_codec_enable_sequencer;

  // ==========================================================================
  // Shortened step counts and register indices
  localparam int unsigned START_R  = 4;
  localparam int unsigned START_S  = 3;
  localparam int unsigned STOP_R   = 5;
  localparam int unsigned STOP_S   = 2;
  localparam int          LIMIT    = 4000;
  localparam logic [7:0]  PWR      = codec_seq_pkg::POWER_CTRL_IDX;
  localparam logic [7:0]  SEQ      = codec_seq_pkg::SOFT_SEQ_IDX;

  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire  logic  hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        deep_sleep;
  logic        codec_master_enable;
  logic        codec_regs_reset_n;
  logic [14:0] codec_settings;
  logic        pop_ramp_active;
  logic        seq_busy;
  int          bad_count;
  int          checked;
  int          cycles;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  codec_enable_sequencer #(
    .START_RAMP_CYC   (START_R),
    .START_SETTLE_CYC (START_S),
    .STOP_RAMP_CYC    (STOP_R),
    .STOP_SETTLE_CYC  (STOP_S)
  ) DUT (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .ce                  (ce),
    .hsel                (hsel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .hsize               (hsize),
    .hwdata              (hwdata),
    .hready              (hready),
    .hreadyout           (hreadyout),
    .hresp               (hresp),
    .hrdata              (hrdata),
    .deep_sleep          (deep_sleep),
    .codec_master_enable (codec_master_enable),
    .codec_regs_reset_n  (codec_regs_reset_n),
    .codec_settings      (codec_settings),
    .pop_ramp_active     (pop_ramp_active),
    .seq_busy            (seq_busy)
  );

  // ==========================================================================
  // Clock and hang guard
  initial hclk = 1'b0;
  always #2.5 hclk = ~hclk;

  // Cut the run short if the tests hang
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      bad_count++;
      give_verdict();
    end
  end

  // ==========================================================================
  // Verdict and bus tasks
  task automatic give_verdict();
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // One single word transfer; address phase held until ready
  task automatic bus_xfer(input logic wr, input logic [7:0] idx,
                          input logic [15:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h000000, idx, 2'b00};
    htrans <= codec_seq_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    `CHECK(hresp, codec_seq_pkg::HRESP_OKAY)
  endtask : bus_xfer

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic [31:0] x;
    bus_xfer(1'b1, idx, d, x);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [15:0] exp);
    logic [31:0] x;
    bus_xfer(1'b0, idx, 16'h0000, x);
    `CHECK(x, {16'h0000, exp})
  endtask : rd_chk

  // Fire a trigger, time the enable change and the end of the sequence
  task automatic run_seq(input logic [15:0] trig, input int ramp,
                         input int settle, input logic en_after);
    int n;
    int m;
    n = 0;
    m = 0;
    wr(SEQ, trig);
    do
    begin
      @(posedge hclk);
      #1;
      n++;
      if (n == 1)
      begin
        `CHECK(pop_ramp_active, 1'b1)
        `CHECK(seq_busy, 1'b1)
      end
    end while (codec_master_enable !== en_after && n < 50);
    `CHECK(n, ramp + 1)
    while (seq_busy !== 1'b0 && m < 50)
    begin
      @(posedge hclk);
      #1;
      m++;
    end
    `CHECK(m, settle)
    rd_chk(SEQ, 16'h0000);
  endtask : run_seq

  // ==========================================================================
  // Main sequence
  initial
  begin
    bad_count  = 0;
    checked    = 0;
    hresetn    = 1'b0;
    ce         = 1'b1;
    hsel       = 1'b0;
    haddr      = 32'h00000000;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hsize      = 3'h2;
    hwdata     = 32'h00000000;
    deep_sleep = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    `CHECK(codec_master_enable, 1'b0)
    `CHECK(seq_busy, 1'b0)
    rd_chk(PWR, 16'h0000);
    rd_chk(SEQ, 16'h0000);
    wr(8'h10, 16'hffff);
    rd_chk(8'h10, 16'h0000);
    wr(PWR, 16'h1234);
    #1;
    `CHECK(codec_settings, 15'h0000)
    `CHECK(codec_regs_reset_n, 1'b0)
    rd_chk(PWR, 16'h0000);
    wr(PWR, 16'h8123);
    #1;
    `CHECK(codec_regs_reset_n, 1'b1)
    `CHECK(codec_settings, 15'h0123)
    rd_chk(PWR, 16'h8123);
    wr(PWR, 16'h0123);
    #1;
    `CHECK(codec_settings, 15'h0000)
    rd_chk(PWR, 16'h0000);
    run_seq(16'h8000, START_R, START_S, 1'b1);
    rd_chk(PWR, 16'h8000);
    wr(PWR, 16'h80aa);
    run_seq(16'h4000, STOP_R, STOP_S, 1'b0);
    `CHECK(codec_settings, 15'h0000)
    rd_chk(PWR, 16'h0000);
    run_seq(16'h8000, START_R, START_S, 1'b1);
    run_seq(16'hc000, STOP_R, STOP_S, 1'b0);
    // Trigger writes while a sequence runs are ignored
    wr(SEQ, 16'h8000);
    wr(SEQ, 16'h4000);
    rd_chk(SEQ, 16'h8000);
    repeat (START_R + START_S + 4) @(posedge hclk);
    #1;
    `CHECK(codec_master_enable, 1'b1)
    rd_chk(SEQ, 16'h0000);
    // Clock enable low stalls the bus
    @(posedge hclk);
    ce <= 1'b0;
    @(posedge hclk);
    #1;
    `CHECK(hreadyout, 1'b0)
    @(posedge hclk);
    ce <= 1'b1;
    // Deep sleep drops the enable and the settings
    wr(PWR, 16'h8077);
    @(posedge hclk);
    deep_sleep <= 1'b1;
    repeat (4) @(posedge hclk);
    #1;
    `CHECK(codec_master_enable, 1'b0)
    `CHECK(codec_regs_reset_n, 1'b0)
    wr(PWR, 16'h8011);
    #1;
    `CHECK(codec_master_enable, 1'b0)
    @(posedge hclk);
    deep_sleep <= 1'b0;
    repeat (4) @(posedge hclk);
    #1;
    `CHECK(codec_settings, 15'h0000)
    rd_chk(PWR, 16'h0000);
    give_verdict();
  end

endmodule : tb_codec_enable_sequencer
